// ### logic/ppp_pkg.sv
// Notes on behaviour
// - action 1,0 with low byte select 0 loads the bus as command.
// - action 0,0 with low byte select 0 loads the low address byte.
// - action 0,1 loads a data byte; low byte select picks low or high.
// - programmer raises low byte select before loading the high data byte.
// - page latch pulse with low byte select 1 stores data at low address.
// - action 0,0 with low byte select 1 loads the high address byte.
// - after a write the programmer waits for ready high, or until the wait limit runs out, before the next operation.
// - command 0x00 is a no-operation and ends page programming.
// - eeprom write command; write pulse with low byte select 0 programs page.
// - fuse write of low data byte; byte selects pick low, high, extended.
package ppp_pkg;

   localparam int CLK_PERIOD_NS = 25;
   localparam int PULSE_NS = 250;
   localparam int SETUP_NS = 100;
   localparam int READ_NS = 250;
   localparam int WAIT_LIMIT_US = 10000;
   localparam int PULSE_CYCLES = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SETUP_CYCLES = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int READ_CYCLES = (READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WAIT_LIMIT_CYCLES = (WAIT_LIMIT_US * 1000) / CLK_PERIOD_NS;

   localparam int TMR_W = 19;
   typedef logic [TMR_W-1:0] ppp_count_type;

   localparam int ADDR_W = 8;
   localparam logic [7:0] REG_CMD = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;

   localparam int ST_BUSY = 0;
   localparam int ST_READY = 1;
   localparam int ST_REFUSED = 2;
   localparam int ST_TIMEOUT = 3;
   localparam int ST_RDATA_LSB = 8;
   localparam int CMD_W = 15;

   typedef enum logic [2:0] {
      OP_NONE = 3'h0,
      OP_LOAD = 3'h1,
      OP_LATCH = 3'h2,
      OP_WRITE = 3'h3,
      OP_READ = 3'h4,
      OP_END = 3'h5
   } ppp_op_type;

   localparam logic [1:0] ACT_ADDR = 2'h0;
   localparam logic [1:0] ACT_DATA = 2'h1;
   localparam logic [1:0] ACT_CMD = 2'h2;
   localparam logic [1:0] ACT_IDLE = 2'h3;

   localparam logic [7:0] CMD_NOP = 8'h00;
   localparam logic [7:0] CMD_WRITE_FLASH = 8'h10;
   localparam logic [7:0] CMD_WRITE_EEPROM = 8'h11;
   localparam logic [7:0] CMD_WRITE_FUSE = 8'h40;
   localparam logic [7:0] CMD_WRITE_LOCK = 8'h20;
   localparam logic [7:0] CMD_READ_SIG = 8'h08;
   localparam logic [7:0] CMD_READ_FUSE_LOCK = 8'h04;
   localparam logic [7:0] CMD_READ_FLASH = 8'h02;
   localparam logic [7:0] CMD_READ_EEPROM = 8'h03;

   // software order word: [2:0] op, [4:3] action, [5] low sel, [6] high sel, [14:7] data
   typedef struct packed {
      logic [7:0] data;
      logic byte_sel_high;
      logic byte_sel_low;
      logic [1:0] action;
      ppp_op_type op;
   } ppp_cmd_type;

   typedef struct packed {
      logic action_code_bit1;
      logic action_code_bit0;
      logic byte_sel_low;
      logic byte_sel_high;
      logic load_strobe;
      logic page_latch_strobe;
      logic write_n;
      logic out_enable_n;
   } ppp_pins_type;

   localparam ppp_pins_type PINS_RESET = '{
      action_code_bit1: 1'b1,
      action_code_bit0: 1'b1,
      byte_sel_low: 1'b0,
      byte_sel_high: 1'b0,
      load_strobe: 1'b0,
      page_latch_strobe: 1'b0,
      write_n: 1'b1,
      out_enable_n: 1'b1
   };

endpackage : ppp_pkg

// ### logic/ppp_timer.sv
`timescale 1ns/100ps
module ppp_timer (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic start,
   input wire ppp_pkg::ppp_count_type load,
   output logic done
);

   ppp_pkg::ppp_count_type cnt_q;
   logic done_q;

   // done rises load+1 edges after start; load of 0 never finishes
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         cnt_q <= '0;
      end else if (start) begin
         cnt_q <= load;
      end else if (cnt_q != '0) begin
         cnt_q <= cnt_q - 1'b1;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         done_q <= 1'b0;
      end else begin
         done_q <= (cnt_q == ppp_pkg::ppp_count_type'(1)) && !start;
      end
   end

   assign done = done_q;

endmodule : ppp_timer

// ### logic/ppp_programmer.sv
`timescale 1ns/100ps
module ppp_programmer #(
   parameter int unsigned WAIT_LIMIT = ppp_pkg::WAIT_LIMIT_CYCLES
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   output ppp_pkg::ppp_pins_type pins,
   output logic [7:0] data_out,
   output logic data_oe,
   input wire logic [7:0] data_in,
   input wire logic ready_flag
);

   typedef enum logic [5:0] {
      S_IDLE = 6'h01,
      S_SETUP = 6'h02,
      S_PULSE = 6'h04,
      S_HOLD = 6'h08,
      S_WAIT = 6'h10,
      S_SAMPLE = 6'h20
   } ppp_state_type;

   localparam ppp_pkg::ppp_count_type SETUP_LOAD =
      ppp_pkg::ppp_count_type'(ppp_pkg::SETUP_CYCLES - 1);
   localparam ppp_pkg::ppp_count_type PULSE_LOAD =
      ppp_pkg::ppp_count_type'(ppp_pkg::PULSE_CYCLES - 1);
   localparam ppp_pkg::ppp_count_type READ_LOAD =
      ppp_pkg::ppp_count_type'(ppp_pkg::READ_CYCLES - 1);
   localparam ppp_pkg::ppp_count_type WAIT_LOAD =
      ppp_pkg::ppp_count_type'(WAIT_LIMIT - 1);

   ppp_state_type st_q;
   ppp_state_type st_d;
   ppp_pkg::ppp_cmd_type cmd_q;
   ppp_pkg::ppp_cmd_type wcmd;
   ppp_pkg::ppp_pins_type pins_q;
   ppp_pkg::ppp_count_type tmr_load;
   logic [7:0] data_out_q;
   logic data_oe_q;
   logic [7:0] rbyte_q;
   logic [31:0] rdata_q;
   logic refused_q;
   logic timeout_q;
   logic tmr_start;
   logic tmr_done;
   logic cmd_wr;
   logic op_ok;
   logic accept;
   logic refused;
   logic timeout;
   logic busy;
   logic status_wr;

   assign wcmd = ppp_pkg::ppp_cmd_type'(reg_wdata[ppp_pkg::CMD_W-1:0]);
   assign cmd_wr = reg_wr && (reg_addr == ppp_pkg::REG_CMD);
   assign status_wr = reg_wr && (reg_addr == ppp_pkg::REG_STATUS);
   assign op_ok = (wcmd.op != ppp_pkg::OP_NONE) && (wcmd.op <= ppp_pkg::OP_END);
   assign accept = cmd_wr && (st_q == S_IDLE) && op_ok;
   // an order during a running step is dropped, never queued
   assign refused = cmd_wr && (st_q != S_IDLE);
   assign busy = (st_q != S_IDLE);
   assign timeout = (st_q == S_WAIT) && tmr_done && !ready_flag;

   ppp_timer u_timer (
      .clk_sys(clk_sys),
      .rst(rst),
      .start(tmr_start),
      .load(tmr_load),
      .done(tmr_done)
   );

   always_comb begin
      st_d = st_q;
      tmr_start = 1'b0;
      tmr_load = '0;
      case (st_q)
         S_IDLE: begin
            if (accept) begin
               st_d = S_SETUP;
               tmr_start = 1'b1;
               tmr_load = SETUP_LOAD;
            end
         end
         S_SETUP: begin
            if (tmr_done) begin
               tmr_start = 1'b1;
               if (cmd_q.op == ppp_pkg::OP_READ) begin
                  st_d = S_SAMPLE;
                  tmr_load = READ_LOAD;
               end else begin
                  st_d = S_PULSE;
                  tmr_load = PULSE_LOAD;
               end
            end
         end
         S_PULSE: begin
            if (tmr_done) begin
               st_d = S_HOLD;
               tmr_start = 1'b1;
               tmr_load = PULSE_LOAD;
            end
         end
         S_HOLD: begin
            // hold also gives the device time to pull ready low after a write
            if (tmr_done) begin
               if (cmd_q.op == ppp_pkg::OP_WRITE) begin
                  st_d = S_WAIT;
                  tmr_start = 1'b1;
                  tmr_load = WAIT_LOAD;
               end else begin
                  st_d = S_IDLE;
               end
            end
         end
         S_WAIT: begin
            if (ready_flag || tmr_done) begin
               st_d = S_IDLE;
            end
         end
         S_SAMPLE: begin
            if (tmr_done) begin
               st_d = S_IDLE;
            end
         end
         default: begin
            st_d = S_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         st_q <= S_IDLE;
      end else begin
         st_q <= st_d;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         cmd_q <= '0;
      end else if (accept) begin
         cmd_q <= wcmd;
      end
   end

   // pin levels settle in setup, strobe fires in pulse, released in hold; a read drives output enable low in sample instead, released at its end
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pins_q <= ppp_pkg::PINS_RESET;
         data_out_q <= 8'h00;
         data_oe_q <= 1'b0;
      end else if (accept) begin
         case (wcmd.op)
            ppp_pkg::OP_LOAD: begin
               pins_q.action_code_bit1 <= wcmd.action[1];
               pins_q.action_code_bit0 <= wcmd.action[0];
               pins_q.byte_sel_low <= wcmd.byte_sel_low;
               pins_q.byte_sel_high <= wcmd.byte_sel_high;
               data_out_q <= wcmd.data;
               data_oe_q <= 1'b1;
            end
            ppp_pkg::OP_END: begin
               {pins_q.action_code_bit1, pins_q.action_code_bit0} <= ppp_pkg::ACT_CMD;
               pins_q.byte_sel_low <= 1'b0;
               data_out_q <= ppp_pkg::CMD_NOP;
               data_oe_q <= 1'b1;
            end
            ppp_pkg::OP_LATCH: begin
               {pins_q.action_code_bit1, pins_q.action_code_bit0} <= ppp_pkg::ACT_IDLE;
               pins_q.byte_sel_low <= 1'b1;
            end
            ppp_pkg::OP_WRITE: begin
               {pins_q.action_code_bit1, pins_q.action_code_bit0} <= ppp_pkg::ACT_IDLE;
               pins_q.byte_sel_low <= wcmd.byte_sel_low;
               pins_q.byte_sel_high <= wcmd.byte_sel_high;
            end
            ppp_pkg::OP_READ: begin
               {pins_q.action_code_bit1, pins_q.action_code_bit0} <= ppp_pkg::ACT_IDLE;
               pins_q.byte_sel_low <= wcmd.byte_sel_low;
               pins_q.byte_sel_high <= wcmd.byte_sel_high;
               data_oe_q <= 1'b0;
            end
            default: begin
               data_oe_q <= data_oe_q;
            end
         endcase
      end else if ((st_q == S_SETUP) && tmr_done) begin
         case (cmd_q.op)
            ppp_pkg::OP_LOAD, ppp_pkg::OP_END: begin
               pins_q.load_strobe <= 1'b1;
            end
            ppp_pkg::OP_LATCH: begin
               pins_q.page_latch_strobe <= 1'b1;
            end
            ppp_pkg::OP_WRITE: begin
               pins_q.write_n <= 1'b0;
            end
            ppp_pkg::OP_READ: begin
               pins_q.out_enable_n <= 1'b0;
            end
            default: begin
               pins_q.write_n <= 1'b1;
            end
         endcase
      end else if ((st_q == S_PULSE) && tmr_done) begin
         pins_q.load_strobe <= 1'b0;
         pins_q.page_latch_strobe <= 1'b0;
         pins_q.write_n <= 1'b1;
      end else if ((st_q == S_SAMPLE) && tmr_done) begin
         pins_q.out_enable_n <= 1'b1;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rbyte_q <= 8'h00;
      end else if ((st_q == S_SAMPLE) && tmr_done) begin
         rbyte_q <= data_in;
      end
   end

   // sticky flags: a new event wins over a clear in the same cycle
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         refused_q <= 1'b0;
         timeout_q <= 1'b0;
      end else begin
         if (refused) begin
            refused_q <= 1'b1;
         end else if (status_wr && reg_wdata[ppp_pkg::ST_REFUSED]) begin
            refused_q <= 1'b0;
         end
         if (timeout) begin
            timeout_q <= 1'b1;
         end else if (status_wr && reg_wdata[ppp_pkg::ST_TIMEOUT]) begin
            timeout_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rdata_q <= 32'h0000_0000;
      end else begin
         rdata_q <= 32'h0000_0000;
         if (reg_rd) begin
            case (reg_addr)
               ppp_pkg::REG_CMD: begin
                  rdata_q[ppp_pkg::CMD_W-1:0] <= cmd_q;
               end
               ppp_pkg::REG_STATUS: begin
                  rdata_q[ppp_pkg::ST_BUSY] <= busy;
                  rdata_q[ppp_pkg::ST_READY] <= ready_flag;
                  rdata_q[ppp_pkg::ST_REFUSED] <= refused_q;
                  rdata_q[ppp_pkg::ST_TIMEOUT] <= timeout_q;
                  rdata_q[ppp_pkg::ST_RDATA_LSB+:8] <= rbyte_q;
               end
               default: begin
                  rdata_q <= 32'h0000_0000;
               end
            endcase
         end
      end
   end

   assign reg_rdata = rdata_q;
   assign pins = pins_q;
   assign data_out = data_out_q;
   assign data_oe = data_oe_q;

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   sequence s_load_high10;
      pins_q.load_strobe [*8] ##1 pins_q.load_strobe ##1 pins_q.load_strobe;
   endsequence

   sequence s_write_low10;
      !pins_q.write_n [*8] ##1 !pins_q.write_n ##1 !pins_q.write_n;
   endsequence

   a_load_pulse_width: assert property (
      $rose(pins_q.load_strobe) |-> s_load_high10 ##1 !pins_q.load_strobe)
      else $error("load strobe not ten cycles high");

   a_write_pulse_width: assert property (
      $fell(pins_q.write_n) |-> s_write_low10 ##1 pins_q.write_n ##1 busy)
      else $error("write pulse not ten cycles low");

   a_load_lines_stable: assert property (
      $past(pins_q.load_strobe) && pins_q.load_strobe |->
         $stable(data_out_q) && $stable(pins_q.action_code_bit1) &&
         $stable(pins_q.action_code_bit0) && $stable(pins_q.byte_sel_low))
      else $error("lines moved during load strobe");

   a_latch_sel_low: assert property (
      pins_q.page_latch_strobe |-> pins_q.byte_sel_low)
      else $error("page latch without low byte select");

   a_bus_turnaround: assert property (
      data_oe_q |-> pins_q.out_enable_n)
      else $error("host drives bus while output enable low");

   a_end_sends_nop: assert property (
      accept && (wcmd.op == ppp_pkg::OP_END) |-> ##5 ($rose(pins_q.load_strobe) &&
         (data_out_q == ppp_pkg::CMD_NOP) && pins_q.action_code_bit1 &&
         !pins_q.action_code_bit0 && data_oe_q))
      else $error("end order did not load the no-operation command");

   a_wait_quiet: assert property (
      st_q == S_WAIT |-> !pins_q.load_strobe && pins_q.write_n &&
         !pins_q.page_latch_strobe && pins_q.out_enable_n)
      else $error("strobe issued while waiting for ready");

   a_ready_ends_wait: assert property (
      (st_q == S_WAIT) && ready_flag |=> (st_q == S_IDLE) ##1 !rdata_q[ppp_pkg::ST_BUSY])
      else $error("ready did not end the wait");

   a_read_capture: assert property (
      (st_q == S_SAMPLE) && tmr_done |=> (rbyte_q == $past(data_in)) &&
         pins_q.out_enable_n && !data_oe_q)
      else $error("read byte not captured at end of sample");

   a_refused_sticky: assert property (
      refused |=> refused_q)
      else $error("dropped order not flagged");

   a_status_read: assert property (
      reg_rd && (reg_addr == ppp_pkg::REG_STATUS) |=>
         rdata_q[ppp_pkg::ST_BUSY] == $past(busy))
      else $error("status busy bit wrong");

endmodule : ppp_programmer

// ### verification/ppp_dev_model.sv
`timescale 1ns/100ps
module ppp_dev_model #(
   parameter logic [7:0] SIG0 = 8'h3c, // arbitrary
   parameter logic [7:0] SIG1 = 8'h5d, // arbitrary
   parameter logic [7:0] SIG2 = 8'h7e // arbitrary
) (
   input wire logic clk_sys,
   input wire ppp_pkg::ppp_pins_type pins,
   input wire logic [7:0] bus,
   input wire logic [15:0] busy_len,
   output logic [7:0] dev_q,
   output logic dev_oe,
   output logic ready_flag
);
   ppp_pkg::ppp_pins_type prev_q = ppp_pkg::PINS_RESET;
   logic [7:0] cmd_q = 8'h00, alo_q = 8'h00, ahi_q = 8'h00;
   logic [7:0] dlo_q, dhi_q, lock_q = 8'hff;
   logic [7:0] fuse_q [3] = '{8'hff, 8'hff, 8'hff};
   logic [15:0] fbuf [64], flash [256], busy_q = 16'h0;
   logic [7:0] ebuf [4], eep [256];
   wire logic [1:0] sel = {pins.byte_sel_high, pins.byte_sel_low};
   always @(posedge clk_sys) begin
      prev_q <= pins;
      if (busy_q != 16'h0) busy_q <= busy_q - 16'h1;
      if (pins.load_strobe && !prev_q.load_strobe) begin
         case ({pins.action_code_bit1, pins.action_code_bit0})
            2'h2: if (!pins.byte_sel_low) cmd_q <= bus;
            2'h0: if (pins.byte_sel_low) ahi_q <= bus; else alo_q <= bus;
            2'h1: if (pins.byte_sel_low) dhi_q <= bus; else dlo_q <= bus;
            default: ;
         endcase
      end
      if (pins.page_latch_strobe && !prev_q.page_latch_strobe &&
         pins.byte_sel_low) begin
         fbuf[alo_q[5:0]] <= {dhi_q, dlo_q};
         ebuf[alo_q[1:0]] <= dlo_q;
      end
      if (!pins.write_n && prev_q.write_n && cmd_q != ppp_pkg::CMD_NOP) begin
         busy_q <= busy_len;
         case (cmd_q)
            ppp_pkg::CMD_WRITE_FLASH: for (int i = 0; i < 64; i++) begin
               flash[{alo_q[7:6], 6'(i)}] <= fbuf[i];
            end
            ppp_pkg::CMD_WRITE_EEPROM: if (!pins.byte_sel_low) begin
               for (int i = 0; i < 4; i++) eep[{alo_q[7:2], 2'(i)}] <= ebuf[i];
            end
            ppp_pkg::CMD_WRITE_FUSE: if (sel != 2'h3) fuse_q[sel] <= dlo_q;
            ppp_pkg::CMD_WRITE_LOCK: if (lock_q[1:0] != 2'h0) begin
               lock_q <= lock_q & dlo_q;
            end
            default: ;
         endcase
      end
   end
   assign ready_flag = (busy_q == 16'h0);
   assign dev_oe = !pins.out_enable_n;
   always_comb begin
      case (cmd_q)
         ppp_pkg::CMD_READ_FLASH: dev_q = pins.byte_sel_low ? flash[alo_q][15:8] :
            flash[alo_q][7:0];
         ppp_pkg::CMD_READ_EEPROM: dev_q = eep[alo_q];
         ppp_pkg::CMD_READ_FUSE_LOCK: dev_q = (sel == 2'h1) ? lock_q : (sel == 2'h3) ? fuse_q[1] :
            (sel == 2'h2) ? fuse_q[2] : fuse_q[0];
         ppp_pkg::CMD_READ_SIG: dev_q = (alo_q == 8'h00) ? SIG0 :
            (alo_q == 8'h01) ? SIG1 : SIG2;
         default: dev_q = 8'h00;
      endcase
   end
endmodule : ppp_dev_model

// ### verification/tb.sv
`timescale 1ns/100ps
module tb;
   logic clk_sys = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [7:0] reg_addr = 8'h00, data_out, dev_q, idle_q = 8'h5a;
   logic [31:0] reg_wdata = 32'h0, reg_rdata, stat;
   logic [15:0] busy_len = 16'h1e;
   logic data_oe, dev_oe, ready_flag;
   ppp_pkg::ppp_pins_type pins;
   int errors = 0, total_checks = 0;
   // released bus shows a changing pattern rather than the last value
   wire logic [7:0] data_in = dev_oe ? dev_q : (data_oe ? data_out : idle_q);
   ppp_programmer #(.WAIT_LIMIT(50)) i_dut (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pins(pins),
      .data_out(data_out), .data_oe(data_oe), .data_in(data_in), .ready_flag(ready_flag));
   ppp_dev_model i_model (.clk_sys(clk_sys), .pins(pins), .bus(data_in), .busy_len(busy_len),
      .dev_q(dev_q), .dev_oe(dev_oe), .ready_flag(ready_flag));
   initial begin
      forever #12.5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) idle_q <= ~idle_q;
   task automatic end_of_test;
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : end_of_test
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
      @(posedge clk_sys);
   endtask : rd
   task automatic wait_idle;
      for (int i = 0; i < 3000; i++) begin
         rd(ppp_pkg::REG_STATUS, stat);
         if (stat[ppp_pkg::ST_BUSY] === 1'b0) return;
      end
      chk(stat, 32'h0);
   endtask : wait_idle
   task automatic order(input ppp_pkg::ppp_op_type o, input logic [1:0] a, input logic l,
                        input logic h, input logic [7:0] d);
      ppp_pkg::ppp_cmd_type c;
      c = '{data: d, byte_sel_high: h, byte_sel_low: l, action: a, op: o};
      wr(ppp_pkg::REG_CMD, {17'h0, c});
      wait_idle();
   endtask : order
   task automatic ld(input logic [1:0] a, input logic l, input logic [7:0] d);
      order(ppp_pkg::OP_LOAD, a, l, 1'b0, d);
   endtask : ld
   task automatic rdb(input logic l, input logic h, input logic [7:0] exp);
      order(ppp_pkg::OP_READ, ppp_pkg::ACT_IDLE, l, h, 8'h00);
      chk({24'h0, stat[15:8]}, {24'h0, exp});
   endtask : rdb
   task automatic t_reset;
      chk({24'h0, pins}, {24'h0, ppp_pkg::PINS_RESET});
      chk({31'h0, data_oe}, 32'h0);
      rd(ppp_pkg::REG_STATUS, stat);
      chk(stat[3:0], 4'h2);
   endtask : t_reset
   task automatic t_flash;
      ld(ppp_pkg::ACT_CMD, 1'b0, ppp_pkg::CMD_WRITE_FLASH);
      for (int w = 0; w < 2; w++) begin
         ld(ppp_pkg::ACT_ADDR, 1'b0, 8'h40 + 8'(w));
         ld(ppp_pkg::ACT_DATA, 1'b0, 8'hc0 + 8'(w));
         ld(ppp_pkg::ACT_DATA, 1'b1, 8'h30 + 8'(w));
         order(ppp_pkg::OP_LATCH, ppp_pkg::ACT_IDLE, 1'b1, 1'b0, 8'h00);
      end
      ld(ppp_pkg::ACT_ADDR, 1'b1, 8'h00);
      order(ppp_pkg::OP_WRITE, ppp_pkg::ACT_IDLE, 1'b0, 1'b0, 8'h00);
      order(ppp_pkg::OP_END, ppp_pkg::ACT_CMD, 1'b0, 1'b0, 8'h00);
      ld(ppp_pkg::ACT_CMD, 1'b0, ppp_pkg::CMD_READ_FLASH);
      for (int w = 0; w < 2; w++) begin
         ld(ppp_pkg::ACT_ADDR, 1'b0, 8'h40 + 8'(w));
         rdb(1'b0, 1'b0, 8'hc0 + 8'(w));
         rdb(1'b1, 1'b0, 8'h30 + 8'(w));
      end
   endtask : t_flash
   task automatic t_eeprom;
      ld(ppp_pkg::ACT_CMD, 1'b0, ppp_pkg::CMD_WRITE_EEPROM);
      ld(ppp_pkg::ACT_ADDR, 1'b0, 8'h25);
      ld(ppp_pkg::ACT_DATA, 1'b0, 8'h9e);
      order(ppp_pkg::OP_LATCH, ppp_pkg::ACT_IDLE, 1'b1, 1'b0, 8'h00);
      order(ppp_pkg::OP_WRITE, ppp_pkg::ACT_IDLE, 1'b0, 1'b0, 8'h00);
      ld(ppp_pkg::ACT_CMD, 1'b0, ppp_pkg::CMD_READ_EEPROM);
      rdb(1'b0, 1'b0, 8'h9e);
   endtask : t_eeprom
   task automatic t_fuse_lock;
      logic [7:0] val [3] = '{8'h62, 8'hd9, 8'hf7};
      logic [1:0] wsel [3] = '{2'h0, 2'h1, 2'h2};
      logic [1:0] rsel [3] = '{2'h0, 2'h3, 2'h2};
      ld(ppp_pkg::ACT_CMD, 1'b0, ppp_pkg::CMD_WRITE_FUSE);
      for (int i = 0; i < 3; i++) begin
         ld(ppp_pkg::ACT_DATA, 1'b0, val[i]);
         order(ppp_pkg::OP_WRITE, ppp_pkg::ACT_IDLE, wsel[i][0], wsel[i][1], 8'h00);
      end
      ld(ppp_pkg::ACT_CMD, 1'b0, ppp_pkg::CMD_WRITE_LOCK);
      ld(ppp_pkg::ACT_DATA, 1'b0, 8'hfc);
      order(ppp_pkg::OP_WRITE, ppp_pkg::ACT_IDLE, 1'b0, 1'b0, 8'h00);
      ld(ppp_pkg::ACT_DATA, 1'b0, 8'hf3);
      order(ppp_pkg::OP_WRITE, ppp_pkg::ACT_IDLE, 1'b0, 1'b0, 8'h00);
      ld(ppp_pkg::ACT_CMD, 1'b0, ppp_pkg::CMD_READ_FUSE_LOCK);
      for (int i = 0; i < 3; i++) rdb(rsel[i][0], rsel[i][1], val[i]);
      rdb(1'b1, 1'b0, 8'hfc);
   endtask : t_fuse_lock
   task automatic t_sig;
      logic [7:0] sig [3] = '{8'h3c, 8'h5d, 8'h7e};
      ld(ppp_pkg::ACT_CMD, 1'b0, ppp_pkg::CMD_READ_SIG);
      for (int i = 0; i < 3; i++) begin
         ld(ppp_pkg::ACT_ADDR, 1'b0, 8'(i));
         rdb(1'b0, 1'b0, sig[i]);
      end
   endtask : t_sig
   task automatic t_refuse_timeout;
      // strobe held two cycles: the second write meets a busy step
      reg_addr <= ppp_pkg::REG_CMD;
      reg_wdata <= {17'h0, 8'h00, 4'h3, ppp_pkg::OP_LOAD};
      reg_wr <= 1'b1;
      repeat (2) @(posedge clk_sys);
      reg_wr <= 1'b0;
      wait_idle();
      chk(stat[ppp_pkg::ST_REFUSED], 1'b1);
      rd(ppp_pkg::REG_CMD, stat);
      chk(stat, {17'h0, 8'h00, 4'h3, ppp_pkg::OP_LOAD});
      wr(ppp_pkg::REG_STATUS, 32'h4);
      rd(ppp_pkg::REG_STATUS, stat);
      chk(stat[ppp_pkg::ST_REFUSED], 1'b0);
      busy_len <= 16'hc8;
      ld(ppp_pkg::ACT_CMD, 1'b0, ppp_pkg::CMD_WRITE_FUSE);
      ld(ppp_pkg::ACT_DATA, 1'b0, 8'h62);
      order(ppp_pkg::OP_WRITE, ppp_pkg::ACT_IDLE, 1'b0, 1'b0, 8'h00);
      chk(stat[ppp_pkg::ST_TIMEOUT], 1'b1);
      for (int i = 0; i < 400 && stat[ppp_pkg::ST_READY] !== 1'b1; i++) begin
         rd(ppp_pkg::REG_STATUS, stat);
      end
      chk(stat[ppp_pkg::ST_READY], 1'b1);
      busy_len <= 16'h1e;
      wr(ppp_pkg::REG_STATUS, 32'h8);
      rd(ppp_pkg::REG_STATUS, stat);
      chk(stat[ppp_pkg::ST_TIMEOUT], 1'b0);
      wr(ppp_pkg::REG_CMD, 32'h6);
      rd(ppp_pkg::REG_STATUS, stat);
      chk(stat[3:0], 4'h2);
   endtask : t_refuse_timeout
   initial begin
      repeat (60000) @(posedge clk_sys);
      errors++;
      end_of_test();
   end
   initial begin
      repeat (10) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      t_reset();
      t_flash();
      t_eeprom();
      t_fuse_lock();
      t_sig();
      t_refuse_timeout();
      end_of_test();
   end
endmodule : tb
